// ---- src/smc_pkg.sv ----
// Package of constants for the host-side static memory controller.
// Operation
// - A write ends when select or strobe rises, and one of them is high whenever the address moves.
// - The host drives the data pins only after the memory outputs have been turned off.
// - Read and write cycles last at least the cycle minimum, and read data is valid by then.
// - The host holds chip select low for at least the select time before a write ends.
// - The host presents write data at least the setup time before the write ends.
// - The host changes the address no earlier than the end of the write, with zero hold.
// - For a select-started read the address is valid no later than chip select falls.
package smc_pkg;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CLK_PERIOD_NS = 100;
   // Slowest speed grade figures, so any part grade is served.
   localparam int unsigned READ_CYCLE_MIN_NS = 20;
   localparam int unsigned WRITE_CYCLE_MIN_NS = 20;
   localparam int unsigned ADDR_TO_DATA_DELAY_NS = 20;
   localparam int unsigned GATE_TO_DATA_DELAY_NS = 8;
   localparam int unsigned SELECT_TO_WRITE_END_NS = 12;
   localparam int unsigned DATA_SETUP_TO_WRITE_END_NS = 12;
   localparam int unsigned STROBE_TO_FLOAT_NS = 5;
   localparam int unsigned DRIVE_AFTER_WRITE_NS = 3;
   // Least times round up, at least one cycle.
   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int unsigned READ_WAIT_CYC = ns_to_cyc(ADDR_TO_DATA_DELAY_NS);
   localparam int unsigned WRITE_PULSE_CYC = ns_to_cyc(SELECT_TO_WRITE_END_NS);
   localparam int unsigned FLOAT_WAIT_CYC = ns_to_cyc(STROBE_TO_FLOAT_NS);
   localparam int unsigned CNT_W = 4;
   typedef enum logic [2:0] {
      SMC_IDLE,
      SMC_RD_WAIT,
      SMC_WR_FLOAT,
      SMC_WR_PULSE,
      SMC_WR_END
   } smc_state_e;
endpackage

// ---- src/smc_cycle_timer.sv ----
// Down counter that times the phases of a memory cycle.
`timescale 1ns/1ps
module smc_cycle_timer #(
   parameter int unsigned CNT_W = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Control
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] value_i,
   // Status
   output logic                  done_o
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   assign cnt_d = load_i ? value_i : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
   // Done looks only at the count: a load depends on done in the caller, so
   // gating done with load would close a combinational loop.
   assign done_o = (cnt_q == '0);

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule

// ---- src/smc_host.sv ----
// Host controller that runs read and write cycles on an asynchronous 128K by 8 memory.
`timescale 1ns/1ps
module smc_host #(
   parameter int unsigned ADDR_W = smc_pkg::ADDR_W,
   parameter int unsigned DATA_W = smc_pkg::DATA_W
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // User request
   input  wire logic              req_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic                   busy_o,
   output logic                   rvalid_o,
   output logic [DATA_W-1:0]      rdata_o,
   // Memory pins
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic                   chip_select_n_o,
   output logic                   write_strobe_n_o,
   output logic                   output_gate_n_o,
   input  wire logic [DATA_W-1:0] data_pins_i,
   output logic [DATA_W-1:0]      data_pins_o,
   output logic                   data_pins_oe_n_o
);
   localparam logic [smc_pkg::CNT_W-1:0] RD_LOAD =
      smc_pkg::CNT_W'(smc_pkg::READ_WAIT_CYC - 1);
   localparam logic [smc_pkg::CNT_W-1:0] WR_LOAD =
      smc_pkg::CNT_W'(smc_pkg::WRITE_PULSE_CYC - 1);
   localparam logic [smc_pkg::CNT_W-1:0] FL_LOAD =
      smc_pkg::CNT_W'(smc_pkg::FLOAT_WAIT_CYC - 1);

   smc_pkg::smc_state_e state_q;
   smc_pkg::smc_state_e state_d;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rdata_q;
   logic              rvalid_q;
   logic              busy_q;
   logic              cs_n_q;
   logic              we_n_q;
   logic              oe_n_q;
   logic              drv_n_q;
   logic              tmr_load;
   logic [smc_pkg::CNT_W-1:0] tmr_value;
   logic              tmr_done;

   ////////////////////////////////////////////////////////////////////////////
   smc_cycle_timer #(
      .CNT_W (smc_pkg::CNT_W)
   ) u_timer (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .load_i  (tmr_load),
      .value_i (tmr_value),
      .done_o  (tmr_done)
   );

   wire start_rd = (state_q == smc_pkg::SMC_IDLE) && req_i && !we_i;
   wire start_wr = (state_q == smc_pkg::SMC_IDLE) && req_i && we_i;
   wire float_ok = (state_q == smc_pkg::SMC_WR_FLOAT) && tmr_done;
   wire rd_done  = (state_q == smc_pkg::SMC_RD_WAIT) && tmr_done;
   wire wr_end   = (state_q == smc_pkg::SMC_WR_PULSE) && tmr_done;

   assign tmr_load  = start_rd || start_wr || float_ok;
   assign tmr_value = start_rd ? RD_LOAD : (start_wr ? FL_LOAD : WR_LOAD);

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         smc_pkg::SMC_IDLE:
            if (start_rd)
               state_d = smc_pkg::SMC_RD_WAIT;
            else if (start_wr)
               state_d = smc_pkg::SMC_WR_FLOAT;
         smc_pkg::SMC_RD_WAIT:
            if (tmr_done)
               state_d = smc_pkg::SMC_IDLE;
         smc_pkg::SMC_WR_FLOAT:
            if (tmr_done)
               state_d = smc_pkg::SMC_WR_PULSE;
         smc_pkg::SMC_WR_PULSE:
            if (tmr_done)
               state_d = smc_pkg::SMC_WR_END;
         smc_pkg::SMC_WR_END:
            state_d = smc_pkg::SMC_IDLE;
         default:
            state_d = smc_pkg::SMC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         state_q <= smc_pkg::SMC_IDLE;
      else
         state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address and write data are held from the start of a cycle to its end.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         addr_q  <= '0;
         wdata_q <= '0;
      end
      else if (start_rd || start_wr)
      begin
         addr_q  <= addr_i;
         wdata_q <= wdata_i;
      end
   end

   // Select and address change together on a read, both valid by the edge.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         cs_n_q <= 1'b1;
      else if (start_rd || start_wr)
         cs_n_q <= 1'b0;
      else if (rd_done || wr_end)
         cs_n_q <= 1'b1;
   end

   // Gate stays high through writes so the memory never fights our drivers.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         oe_n_q <= 1'b1;
      else if (start_rd)
         oe_n_q <= 1'b0;
      else if (rd_done || start_wr)
         oe_n_q <= 1'b1;
   end

   // Strobe and select rise on the same edge; the write latches there.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         we_n_q <= 1'b1;
      else if (start_wr)
         we_n_q <= 1'b0;
      else if (wr_end)
         we_n_q <= 1'b1;
   end

   // Drivers turn on only after the float wait, and off the cycle after the
   // write ends, giving one cycle of data hold and room before the memory drives.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         drv_n_q <= 1'b1;
      else if (float_ok)
         drv_n_q <= 1'b0;
      else if (state_q == smc_pkg::SMC_WR_END)
         drv_n_q <= 1'b1;
   end

   // Data is sampled one clock cycle after address and gate went out.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= rd_done;
         if (rd_done)
            rdata_q <= data_pins_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         busy_q <= 1'b0;
      else
         busy_q <= (state_d != smc_pkg::SMC_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   assign mem_addr_o       = addr_q;
   assign chip_select_n_o  = cs_n_q;
   assign write_strobe_n_o = we_n_q;
   assign output_gate_n_o  = oe_n_q;
   assign data_pins_o      = wdata_q;
   assign data_pins_oe_n_o = drv_n_q;
   assign rdata_o          = rdata_q;
   assign rvalid_o         = rvalid_q;
   assign busy_o           = busy_q;
endmodule

// ---- verification/smc_host_asserts.sv ----
// Pin-level checks for the host memory controller.
`timescale 1ns/1ps
module smc_host_asserts #(
   parameter int unsigned ADDR_W = 17,
   parameter int unsigned DATA_W = 8
) (
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic              req_i,
   input wire logic              we_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic              busy_o,
   input wire logic              rvalid_o,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic              chip_select_n_o,
   input wire logic              write_strobe_n_o,
   input wire logic              output_gate_n_o,
   input wire logic [DATA_W-1:0] data_pins_i,
   input wire logic [DATA_W-1:0] data_pins_o,
   input wire logic              data_pins_oe_n_o
);
   logic [1:0] settle_q;

   // Checks wait a few edges after reset, so that $past, $rose and $changed never
   // compare a value from before a mid-run reset with one from after it.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         settle_q <= 2'h0;
      else if (settle_q != 2'h3)
         settle_q <= settle_q + 2'h1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i || settle_q != 2'h3);
   sequence s_take(bit w);
      req_i && we_i == w && !busy_o && !rvalid_o && !$past(busy_o);
   endsequence
   sequence s_read_run;
      ##1 (!chip_select_n_o && !output_gate_n_o && mem_addr_o == $past(addr_i))
      ##1 (rvalid_o && chip_select_n_o && rdata_o == $past(data_pins_i));
   endsequence
   sequence s_write_run;
      ##1 (!chip_select_n_o && !write_strobe_n_o && mem_addr_o == $past(addr_i))
      ##1 (!data_pins_oe_n_o && data_pins_o == $past(wdata_i, 2))
      ##1 (chip_select_n_o && write_strobe_n_o) ##1 !busy_o;
   endsequence
   a_read_walk: assert property (s_take(1'b0) |-> s_read_run)
      else $error("read cycle out of order");
   a_write_walk: assert property (s_take(1'b1) |-> s_write_run)
      else $error("write cycle out of order");
   a_gate_in_write: assert property (!write_strobe_n_o |-> output_gate_n_o)
      else $error("gate low during write");
   a_host_drive_safe: assert property (!data_pins_oe_n_o |-> output_gate_n_o)
      else $error("host drives while memory may drive");
   a_float_first: assert property
      ($fell(data_pins_oe_n_o) |-> !write_strobe_n_o && !$past(write_strobe_n_o))
      else $error("host drove before float time");
   a_addr_moves: assert property ($changed(mem_addr_o) |-> $past(write_strobe_n_o))
      else $error("address moved inside write");
   a_select_width: assert property
      ($rose(write_strobe_n_o) |-> $rose(chip_select_n_o) && !$past(chip_select_n_o, 2))
      else $error("select too short or not ending");
   a_data_setup: assert property
      ($rose(write_strobe_n_o) |-> !$past(data_pins_oe_n_o) && !data_pins_oe_n_o)
      else $error("write data not held around end");
   a_addr_at_select: assert property
      (!chip_select_n_o && !$fell(chip_select_n_o) |-> $stable(mem_addr_o))
      else $error("address moved after select fell");
endmodule
bind smc_host smc_host_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) smc_host_asserts_inst (
   .clk_i, .nrst_i, .req_i, .we_i, .addr_i, .wdata_i, .busy_o, .rvalid_o, .rdata_o,
   .mem_addr_o, .chip_select_n_o, .write_strobe_n_o, .output_gate_n_o, .data_pins_i,
   .data_pins_o, .data_pins_oe_n_o);

// ---- verification/smc_mem_model.sv ----
// Behavioural model of the 128K by 8 asynchronous static memory.
`timescale 1ns/1ps
module smc_mem_model #(
   parameter int unsigned ACC_NS = 20
) (
   // Memory pins
   input  wire logic [16:0] addr_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        output_gate_n_i,
   input  wire logic [7:0]  data_i,
   output logic [7:0]       data_o,
   output logic             drive_o
);
   logic [7:0] mem [0:131071];
   logic [7:0] last_q;
   wire        wr_act = !chip_select_n_i && !write_strobe_n_i;
   // No clock here: the word lands when select or strobe rises first.
   always @(negedge wr_act) mem[addr_i] = data_i;
   assign drive_o = !chip_select_n_i && !output_gate_n_i && write_strobe_n_i;
   always @* if (drive_o) last_q = mem[addr_i];
   // Released pins show the inverse so a late sample cannot pass by luck.
   assign #(ACC_NS) data_o = drive_o ? mem[addr_i] : ~last_q;
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the host memory controller.
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, we_i = 1'b0;
   logic [16:0] addr_i = 17'h0_0000, mem_addr;
   logic [7:0]  wdata_i = 8'h00, rdata_o, data_pins_o, mem_q, data_pins;
   logic        busy_o, rvalid_o, cs_n, ws_n, og_n, oe_n, mem_drv;
   int          num_errors = 0;
   int          comparisons = 0;
   assign data_pins = oe_n ? mem_q : data_pins_o;
   smc_host smc_host_inst (.clk_i, .nrst_i, .req_i, .we_i, .addr_i, .wdata_i, .busy_o,
      .rvalid_o, .rdata_o, .mem_addr_o(mem_addr), .chip_select_n_o(cs_n),
      .write_strobe_n_o(ws_n), .output_gate_n_o(og_n), .data_pins_i(data_pins),
      .data_pins_o, .data_pins_oe_n_o(oe_n));
   smc_mem_model smc_mem_model_inst (.addr_i(mem_addr), .chip_select_n_i(cs_n),
      .write_strobe_n_i(ws_n), .output_gate_n_i(og_n), .data_i(data_pins),
      .data_o(mem_q), .drive_o(mem_drv));
   initial forever #50 clk_i = ~clk_i;
   task automatic results();
      $display("num_errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle_pins();
      cmp8({1'b0, mem_drv, busy_o, rvalid_o, cs_n, ws_n, og_n, oe_n}, 8'h0F);
   endtask
   // With poke set a read is requested while busy; it must be ignored.
   task automatic do_write(input logic [16:0] a, input logic [7:0] d, input bit poke);
      int n;
      {req_i, we_i, addr_i, wdata_i} = {2'b11, a, d};
      @(negedge clk_i);
      {req_i, we_i, addr_i} = {2'b00, ~a};
      @(negedge clk_i);
      req_i = poke;
      @(negedge clk_i);
      req_i = 1'b0;
      n = 0;
      while (busy_o !== 1'b0)
      begin
         @(negedge clk_i);
         n++;
         if (n > 8)
         begin
            num_errors++;
            $display("mismatch at %0t: write cycle did not finish", $time);
            results();
         end
      end
      cmp8(8'(n), 8'h01);
      @(negedge clk_i);
      idle_pins();
   endtask
   task automatic do_read(input logic [16:0] a, input logic [7:0] exp);
      {req_i, we_i, addr_i} = {2'b10, a};
      @(negedge clk_i);
      req_i = 1'b0;
      @(negedge clk_i);
      cmp8({7'h0, rvalid_o}, 8'h01);
      cmp8(rdata_o, exp);
      @(negedge clk_i);
      idle_pins();
   endtask
   task automatic t_corners();
      logic [16:0] a[4] = '{17'h0_0000, 17'h1_FFFF, 17'h0_0001, 17'h1_0000};
      logic [7:0]  d[4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
      for (int i = 0; i < 4; i++) do_write(a[i], d[i], 1'b0);
      for (int k = 0; k < 8; k++) do_read(a[k % 4], d[k % 4]);
   endtask
   task automatic t_refused();
      do_write(17'h0_0000, 8'hC3, 1'b1);
      do_read(17'h0_0000, 8'hC3);
      do_read(17'h1_FFFF, 8'h5A);
   endtask
   task automatic t_mid_reset();
      {req_i, we_i, addr_i, wdata_i} = {2'b11, 17'h0_0100, 8'h77};
      @(negedge clk_i);
      {req_i, nrst_i} = 2'b00;
      @(negedge clk_i);
      idle_pins();
      nrst_i = 1'b1;
      do_read(17'h1_0000, 8'hFF);
   endtask
   initial
   begin
      repeat (3) @(negedge clk_i);
      nrst_i = 1'b1;
      idle_pins();
      t_corners();
      t_refused();
      t_mid_reset();
      results();
   end
endmodule
